// ===== pkg/thsmy_map.svh
// Offsets, field positions, reset values of the high stamp bank.
// Assumes a 32-bit APB with word-aligned registers.
`ifndef THSMY_MAP_SVH
`define THSMY_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define THSMY_IDX_CTRL        8'h10
`define THSMY_IDX_STATUS      8'h11
`define THSMY_IDX_MONTH       8'h24
`define THSMY_IDX_YEAR        8'h25
`define THSMY_IDX_WIDTH       8

// ----------------------------------------------------------------
// Field widths and positions
// ----------------------------------------------------------------
`define THSMY_MONTH_WIDTH     5
`define THSMY_YEAR_WIDTH      8
`define THSMY_CTRL_ENABLE     0
`define THSMY_CTRL_OVERWRITE  1
`define THSMY_CTRL_CLEAR      2
`define THSMY_STAT_RECORDED   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define THSMY_MONTH_RESET     5'h00
`define THSMY_YEAR_RESET      8'h00
`define THSMY_ENABLE_RESET    1'b0
`define THSMY_OVERWRITE_RESET 1'b0

`endif

// ===== pkg/thsmy_pkg.sv
// Types shared by the high stamp bank.
// Assumes the map header supplies all numbers.
package thsmy_pkg;

    // ------------------------------------------------------------
    // Stamp occupancy
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        THSMY_EMPTY    = 1'b0,
        THSMY_RECORDED = 1'b1
    } thsmy_state_type;

endpackage : thsmy_pkg

// ===== rtl/thsmy_field.sv
// One stamp field: loads on capture, zeroes on clear.
// Assumes load and clear are single-cycle pulses on pclk.
`timescale 1ns/1ps

module thsmy_field #(
    parameter int                 WIDTH       = 8,
    parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             load,
    input  wire logic             clear,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] q
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Capture beats clear so a coincident event is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= RESET_VALUE;
        end else if (load) begin
            q <= din;
        end else if (clear) begin
            q <= '0;
        end
    end

endmodule : thsmy_field

// ===== rtl/thsmy_top.sv
// High temperature stamp bank: month and year with APB access.
// Assumes the calendar and the threshold comparator run on pclk,
// so their signals arrive without synchronisers.
`timescale 1ns/1ps
`include "thsmy_map.svh"

module thsmy_top
    import thsmy_pkg::*;
(
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          high_temp_event,
    input  wire logic [`THSMY_MONTH_WIDTH-1:0] cur_month,
    input  wire logic [`THSMY_YEAR_WIDTH-1:0]  cur_year,
    output logic                               stamp_recorded
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [1:0] WORD_LSB = 2'h0;

    thsmy_state_type                 state;
    thsmy_state_type                 next_state;
    logic                            enable;
    logic                            overwrite_select;
    logic                            setup_phase;
    logic                            access_phase;
    logic                            write_access;
    logic [`THSMY_IDX_WIDTH-1:0]     index;
    logic                            aligned;
    logic                            hit_ctrl;
    logic                            hit_status;
    logic                            hit_month;
    logic                            hit_year;
    logic                            mapped;
    logic                            high_stamp_clear;
    logic                            capture;
    logic [`THSMY_MONTH_WIDTH-1:0]   high_stamp_month;
    logic [`THSMY_YEAR_WIDTH-1:0]    high_stamp_year;
    logic [31:0]                     next_rdata;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign write_access = access_phase && pwrite;

    assign index   = paddr[`THSMY_IDX_WIDTH+1:2];
    assign aligned = (paddr[1:0] == WORD_LSB);

    // Upper address bits must be clear so aliases stay unmapped
    assign hit_ctrl   = aligned && (paddr[11:`THSMY_IDX_WIDTH+2] == '0)
                        && (index == `THSMY_IDX_CTRL);
    assign hit_status = aligned && (paddr[11:`THSMY_IDX_WIDTH+2] == '0)
                        && (index == `THSMY_IDX_STATUS);
    assign hit_month  = aligned && (paddr[11:`THSMY_IDX_WIDTH+2] == '0)
                        && (index == `THSMY_IDX_MONTH);
    assign hit_year   = aligned && (paddr[11:`THSMY_IDX_WIDTH+2] == '0)
                        && (index == `THSMY_IDX_YEAR);
    assign mapped     = hit_ctrl || hit_status || hit_month || hit_year;

    // Zero wait states: read data was fetched during setup
    assign pready = access_phase;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= `THSMY_ENABLE_RESET;
        end else if (write_access && hit_ctrl) begin
            enable <= pwdata[`THSMY_CTRL_ENABLE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overwrite_select <= `THSMY_OVERWRITE_RESET;
        end else if (write_access && hit_ctrl) begin
            overwrite_select <= pwdata[`THSMY_CTRL_OVERWRITE];
        end
    end

    // Clear is a strobe, never stored, so it always reads back 0
    assign high_stamp_clear = write_access && hit_ctrl
                              && pwdata[`THSMY_CTRL_CLEAR];

    // ------------------------------------------------------------
    // Capture decision
    // ------------------------------------------------------------
    // First-event mode locks after one capture until cleared
    assign capture = enable && high_temp_event
                     && (overwrite_select || (state == THSMY_EMPTY));

    always_comb begin
        next_state = state;
        unique case (state)
            THSMY_EMPTY: begin
                if (capture) begin
                    next_state = THSMY_RECORDED;
                end
            end
            THSMY_RECORDED: begin
                // A capture in the clearing cycle keeps the stamp
                if (high_stamp_clear && !capture) begin
                    next_state = THSMY_EMPTY;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= THSMY_EMPTY;
        end else begin
            state <= next_state;
        end
    end

    assign stamp_recorded = (state == THSMY_RECORDED);

    // ------------------------------------------------------------
    // Stamp fields
    // ------------------------------------------------------------
    // Month keeps five bits; the top three are never stored
    thsmy_field #(
        .WIDTH       (`THSMY_MONTH_WIDTH),
        .RESET_VALUE (`THSMY_MONTH_RESET)
    ) u_month (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (capture),
        .clear   (high_stamp_clear),
        .din     (cur_month),
        .q       (high_stamp_month)
    );

    thsmy_field #(
        .WIDTH       (`THSMY_YEAR_WIDTH),
        .RESET_VALUE (`THSMY_YEAR_RESET)
    ) u_year (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (capture),
        .clear   (high_stamp_clear),
        .din     (cur_year),
        .q       (high_stamp_year)
    );

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h00000000;
        if (hit_ctrl) begin
            next_rdata[`THSMY_CTRL_ENABLE]    = enable;
            next_rdata[`THSMY_CTRL_OVERWRITE] = overwrite_select;
        end else if (hit_status) begin
            next_rdata[`THSMY_STAT_RECORDED]  = stamp_recorded;
        end else if (hit_month) begin
            // Bits 7:5 and up stay zero
            next_rdata[`THSMY_MONTH_WIDTH-1:0] = high_stamp_month;
        end else if (hit_year) begin
            next_rdata[`THSMY_YEAR_WIDTH-1:0]  = high_stamp_year;
        end
    end

    // Sampled in setup: a capture in the access cycle shows next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_phase) begin
            prdata <= pwrite ? 32'h00000000 : next_rdata;
        end
    end

    // Writes to the stamp registers are silently dropped, no error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pslverr <= !mapped;
        end
    end

endmodule : thsmy_top

// ===== verification/thsmy_props.sv
// Checker for the high stamp bank, attached to thsmy_top by bind.
// Assumes APB and the capture inputs all run on pclk.
`timescale 1ns/1ps
module thsmy_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        high_temp_event,
    input wire logic        stamp_recorded
);
    logic en;
    wire  acc_ctrl = psel && penable && pwrite && paddr == 12'h040;
    // Mirror of the enable bit, the only hidden state the flag checks need
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            en <= 1'b0;
        else if (acc_ctrl)
            en <= pwdata[0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence rd_setup(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    a_month_upper_zero:
        assert property (rd_setup(12'h090) |=> prdata[31:5] == 27'h0000000)
        else $error("month read shows nonzero upper bits");
    a_year_upper_zero:
        assert property (rd_setup(12'h094) |=> prdata[31:8] == 24'h000000)
        else $error("year read shows nonzero upper bits");
    a_month_empty_zero:
        assert property (rd_setup(12'h090) ##0 !stamp_recorded |=> prdata == 32'h00000000)
        else $error("empty month stamp not zero");
    a_year_empty_zero:
        assert property (rd_setup(12'h094) ##0 !stamp_recorded |=> prdata == 32'h00000000)
        else $error("empty year stamp not zero");
    a_capture_sets_flag:
        assert property (high_temp_event && en && !(acc_ctrl && pwdata[2] && stamp_recorded)
                         |=> stamp_recorded)
        else $error("enabled event not recorded");
    a_disabled_no_capture:
        assert property (!en && !stamp_recorded && !acc_ctrl |=> !stamp_recorded)
        else $error("capture while disabled");
    a_clear_empties:
        assert property (acc_ctrl && pwdata[2] && !(high_temp_event && en) |=> !stamp_recorded)
        else $error("clear left stamp recorded");
endmodule : thsmy_props

bind thsmy_top thsmy_props thsmy_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .high_temp_event(high_temp_event), .stamp_recorded(stamp_recorded));

// ===== verification/tb.sv
// Self-checking bench for the high stamp bank over APB.
// Assumes zero-wait APB and capture one cycle after an enabled event.
`timescale 1ns/1ps
module tb;
    logic        pclk, presetn, psel, penable, pwrite, high_temp_event;
    logic        pready, pslverr, stamp_recorded;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [4:0]  cur_month;
    logic [7:0]  cur_year;
    int          fails, checks_done;

    thsmy_top thsmy_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .high_temp_event(high_temp_event), .cur_month(cur_month),
        .cur_year(cur_year), .stamp_recorded(stamp_recorded));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Waits on pready; the watchdog ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err, input string name);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        if (!wr) check(name, exp, prdata);
        check({name, " error"}, {31'h0, err}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse(input logic [4:0] m, input logic [7:0] y);
        @(posedge pclk);
        high_temp_event <= 1'b1; cur_month <= m; cur_year <= y;
        @(posedge pclk);
        high_temp_event <= 1'b0;
    endtask : pulse

    task finish_test;
        if (fails == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        {psel, penable, pwrite, high_temp_event, presetn} = 5'h00;
        {paddr, pwdata, cur_month, cur_year} = 57'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h090, 0, 32'h00, 0, "month");
        apb(0, 12'h094, 0, 32'h00, 0, "year");
        pulse(5'h05, 8'h24);
        apb(0, 12'h090, 0, 32'h00, 0, "month");
        check("recorded pin", 32'h0, {31'h0, stamp_recorded});
        apb(1, 12'h040, 32'h1, 0, 0, "ctrl");
        pulse(5'h05, 8'h24);
        pulse(5'h12, 8'h99);
        apb(0, 12'h090, 0, 32'h05, 0, "month");
        apb(0, 12'h094, 0, 32'h24, 0, "year");
        apb(0, 12'h044, 0, 32'h01, 0, "status");
        check("recorded pin", 32'h1, {31'h0, stamp_recorded});
        apb(1, 12'h090, 32'hFF, 0, 0, "month");
        apb(1, 12'h094, 32'hFF, 0, 0, "year");
        apb(0, 12'h090, 0, 32'h05, 0, "month");
        apb(0, 12'h094, 0, 32'h24, 0, "year");
        apb(0, 12'h091, 0, 32'h00, 1, "month unaligned");
        apb(1, 12'h040, 32'h3, 0, 0, "ctrl");
        pulse(5'h12, 8'h99);
        apb(0, 12'h090, 0, 32'h12, 0, "month");
        apb(0, 12'h094, 0, 32'h99, 0, "year");
        apb(1, 12'h040, 32'h7, 0, 0, "ctrl");
        apb(0, 12'h090, 0, 32'h00, 0, "month");
        apb(0, 12'h094, 0, 32'h00, 0, "year");
        apb(0, 12'h044, 0, 32'h00, 0, "status");
        check("recorded pin", 32'h0, {31'h0, stamp_recorded});
        pulse(5'h11, 8'h07);
        apb(0, 12'h090, 0, 32'h11, 0, "month");
        apb(0, 12'h094, 0, 32'h07, 0, "year");
        // Mid-run reset must empty a recorded stamp
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h090, 0, 32'h00, 0, "month");
        apb(0, 12'h094, 0, 32'h00, 0, "year");
        apb(0, 12'h040, 0, 32'h00, 0, "ctrl");
        apb(0, 12'h0FC, 0, 32'h00, 1, "unmapped");
        finish_test;
    end

    // Whole sequence needs about a hundred cycles
    initial begin
        #100000;
        fails++;
        finish_test;
    end
endmodule : tb
